// ### pkg/scrb_defines.vh
`ifndef SCRB_DEFINES_VH
`define SCRB_DEFINES_VH
// Register addresses.
`define SCRB_ADDR_CFG_PRI 16'h0000
`define SCRB_ADDR_CFG_SEC 16'h0001
`define SCRB_ADDR_CHAN_PWR 16'h0002
`define SCRB_ADDR_CLASS 16'h0003
// Primary configuration bit positions.
`define SCRB_PRI_RST 0
`define SCRB_PRI_LSB 1
`define SCRB_PRI_ASC 2
`define SCRB_PRI_ASC_M 5
`define SCRB_PRI_LSB_M 6
`define SCRB_PRI_RST_M 7
// Secondary configuration bit positions.
`define SCRB_SEC_DP_RST 1
// Channel power field.
`define SCRB_PWR_LSB 0
`define SCRB_PWR_MSB 1
`define SCRB_PWR_NORMAL 2'h0
`define SCRB_PWR_STANDBY 2'h2
`define SCRB_PWR_DOWN 2'h3
// Reset values.
`define SCRB_RST_BIT 1'h0
`define SCRB_RST_PWR 2'h0
`define SCRB_RST_BYTE 8'h00
// Class code value, arbitrary.
`define SCRB_CLASS_DEFAULT 8'h5A
`endif

// ### rtl/scrb_chan_pwr.v
`timescale 1ns/1ps
`default_nettype none
`include "scrb_defines.vh"
// Power field of one channel and its decoded controls.
module scrb_chan_pwr (
   // Clock and reset
   input wire i_clk,
   input wire i_rst_b,
   input wire i_soft_rst,
   // Write side
   input wire i_wr,
   input wire [1:0] i_wdata,
   // State
   output wire [1:0] o_mode,
   output reg o_clk_en_ff,
   output reg o_dp_hold_ff,
   output reg o_link_en_ff
);
   reg [1:0] mode_ff;
   reg [1:0] nxt_mode;
   always @* begin
      nxt_mode = mode_ff;
      if (i_soft_rst) begin
         nxt_mode = `SCRB_RST_PWR;
      end else if (i_wr) begin
         nxt_mode = i_wdata;
      end
   end
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mode_ff <= `SCRB_RST_PWR;
         o_clk_en_ff <= 1'h1;
         o_dp_hold_ff <= 1'h0;
         o_link_en_ff <= 1'h1;
      end else begin
         mode_ff <= nxt_mode;
         o_clk_en_ff <= (nxt_mode != `SCRB_PWR_STANDBY) && (nxt_mode != `SCRB_PWR_DOWN);
         o_dp_hold_ff <= (nxt_mode == `SCRB_PWR_DOWN);
         o_link_en_ff <= (nxt_mode != `SCRB_PWR_DOWN);
      end
   end
   assign o_mode = mode_ff;
endmodule // scrb_chan_pwr
`default_nettype wire

// ### rtl/scrb_top.v
// Summary of operation
// - Writing 1 to bit 0 or bit 7 of the primary register resets port and registers, and the bit self-clears.
// - Bit 1 (mirror bit 6) selects LSB first when 1 and MSB first when 0, reset 0.
// - Bit 2 (mirror bit 5) makes multibyte addresses increment when 1 and decrement when 0, reset 0.
// - Bits 7, 6, 5 mirror bits 0, 1, 2 on write and read back alike.
// - Writing 1 to bit 1 of the secondary register pulses a datapath reset and self-clears.
// - The channel power field picks normal, standby (clocks off, link on) or power-down (clocks off, held, link off).
// - Power fields are per channel; writes go to all selected channels, reads with both selected return channel A.
`timescale 1ns/1ps
`default_nettype none
`include "scrb_defines.vh"
module scrb_top #(
   parameter NUM_CHAN = 2,
   parameter [7:0] CLASS_CODE = `SCRB_CLASS_DEFAULT
) (
   // Clock and reset
   input wire i_clk,
   input wire i_rst_b,
   // Register access from the serial framer
   input wire i_wr,
   input wire i_rd,
   input wire [15:0] i_addr,
   input wire [7:0] i_wdata,
   input wire [NUM_CHAN-1:0] i_chan_sel,
   output reg [7:0] o_rdata_ff,
   // Serial port controls
   output reg o_lsb_first_ff,
   output reg o_addr_incr_ff,
   output reg o_port_rst_ff,
   output reg o_dp_rst_ff,
   // Channel power controls
   output wire [NUM_CHAN-1:0] o_clk_en,
   output wire [NUM_CHAN-1:0] o_dp_hold,
   output wire [NUM_CHAN-1:0] o_link_en
);
   ////////////////////////////////////////////////////////////////////////////
   function sel_first;
      input [NUM_CHAN-1:0] sel;
      integer k;
      begin
         sel_first = 1'b0;
         for (k = 0; k < NUM_CHAN; k = k + 1) begin
            if (sel[k] && !sel_first) begin
               sel_first = 1'b1;
            end
         end
      end
   endfunction
   wire wr_pri = i_wr && (i_addr == `SCRB_ADDR_CFG_PRI);
   wire wr_sec = i_wr && (i_addr == `SCRB_ADDR_CFG_SEC);
   wire wr_pwr = i_wr && (i_addr == `SCRB_ADDR_CHAN_PWR);
   wire soft_rst = wr_pri && (i_wdata[`SCRB_PRI_RST] || i_wdata[`SCRB_PRI_RST_M]);
   ////////////////////////////////////////////////////////////////////////////
   reg lsb_ff;
   reg asc_ff;
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         lsb_ff <= `SCRB_RST_BIT;
         asc_ff <= `SCRB_RST_BIT;
         o_lsb_first_ff <= `SCRB_RST_BIT;
         o_addr_incr_ff <= `SCRB_RST_BIT;
         o_port_rst_ff <= 1'h0;
         o_dp_rst_ff <= 1'h0;
      end else begin
         o_port_rst_ff <= soft_rst;
         o_dp_rst_ff <= wr_sec && i_wdata[`SCRB_SEC_DP_RST] && !soft_rst;
         if (soft_rst) begin
            lsb_ff <= `SCRB_RST_BIT;
            asc_ff <= `SCRB_RST_BIT;
            o_lsb_first_ff <= `SCRB_RST_BIT;
            o_addr_incr_ff <= `SCRB_RST_BIT;
         end else if (wr_pri) begin
            lsb_ff <= i_wdata[`SCRB_PRI_LSB] | i_wdata[`SCRB_PRI_LSB_M];
            asc_ff <= i_wdata[`SCRB_PRI_ASC] | i_wdata[`SCRB_PRI_ASC_M];
            o_lsb_first_ff <= i_wdata[`SCRB_PRI_LSB] | i_wdata[`SCRB_PRI_LSB_M];
            o_addr_incr_ff <= i_wdata[`SCRB_PRI_ASC] | i_wdata[`SCRB_PRI_ASC_M];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   wire [2*NUM_CHAN-1:0] mode_flat;
   genvar g;
   generate
      for (g = 0; g < NUM_CHAN; g = g + 1) begin : g_chan
         scrb_chan_pwr u_pwr (
            .i_clk(i_clk),
            .i_rst_b(i_rst_b),
            .i_soft_rst(soft_rst),
            .i_wr(wr_pwr && i_chan_sel[g]),
            .i_wdata(i_wdata[`SCRB_PWR_MSB:`SCRB_PWR_LSB]),
            .o_mode(mode_flat[2*g+1:2*g]),
            .o_clk_en_ff(o_clk_en[g]),
            .o_dp_hold_ff(o_dp_hold[g]),
            .o_link_en_ff(o_link_en[g])
         );
      end
   endgenerate
   ////////////////////////////////////////////////////////////////////////////
   reg [1:0] rd_mode;
   integer c;
   always @* begin
      rd_mode = `SCRB_RST_PWR;
      for (c = NUM_CHAN - 1; c >= 0; c = c - 1) begin
         if (i_chan_sel[c]) begin
            rd_mode = mode_flat[2*c +: 2];
         end
      end
   end
   reg [7:0] nxt_rdata;
   always @* begin
      nxt_rdata = `SCRB_RST_BYTE;
      case (i_addr)
         `SCRB_ADDR_CFG_PRI: begin
            nxt_rdata[`SCRB_PRI_LSB] = lsb_ff;
            nxt_rdata[`SCRB_PRI_LSB_M] = lsb_ff;
            nxt_rdata[`SCRB_PRI_ASC] = asc_ff;
            nxt_rdata[`SCRB_PRI_ASC_M] = asc_ff;
         end
         `SCRB_ADDR_CHAN_PWR: begin
            if (sel_first(i_chan_sel)) begin
               nxt_rdata[`SCRB_PWR_MSB:`SCRB_PWR_LSB] = rd_mode;
            end
         end
         `SCRB_ADDR_CLASS: begin
            nxt_rdata = CLASS_CODE;
         end
         default: begin
            nxt_rdata = `SCRB_RST_BYTE;
         end
      endcase
   end
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rdata_ff <= `SCRB_RST_BYTE;
      end else if (i_rd) begin
         o_rdata_ff <= nxt_rdata;
      end
   end
endmodule // scrb_top
`default_nettype wire

// ### testbench/scrb_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module scrb_assertions #(parameter NUM_CHAN = 2, parameter [7:0] CLASS_CODE = 8'h5A) (
   // Watched ports
   input wire logic i_clk, i_rst_b, i_wr, i_rd, o_port_rst_ff, o_dp_rst_ff, o_lsb_first_ff, o_addr_incr_ff,
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_wdata, o_rdata_ff,
   input wire logic [NUM_CHAN-1:0] i_chan_sel, o_dp_hold, o_clk_en, o_link_en
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   wire w0 = i_wr && i_addr == 16'h0000;
   property p_srst; w0 && (i_wdata[0] || i_wdata[7]) |=> o_port_rst_ff && !o_lsb_first_ff; endproperty
   a_srst: assert property (p_srst) else $error("soft reset");
   property p_pulse; o_port_rst_ff |=> !o_port_rst_ff; endproperty
   a_pulse: assert property (p_pulse) else $error("reset pulse");
   property p_lsb; w0 && !i_wdata[0] && !i_wdata[7] |=> o_lsb_first_ff == $past(i_wdata[1] || i_wdata[6]); endproperty
   a_lsb: assert property (p_lsb) else $error("bit order");
   property p_asc; w0 && !i_wdata[0] && !i_wdata[7] |=> o_addr_incr_ff == $past(i_wdata[2] || i_wdata[5]); endproperty
   a_asc: assert property (p_asc) else $error("address direction");
   property p_dp; i_wr && i_addr == 16'h0001 && i_wdata[1] |=> o_dp_rst_ff; endproperty
   a_dp: assert property (p_dp) else $error("datapath reset");
   property p_dpclr; o_dp_rst_ff |=> !o_dp_rst_ff; endproperty
   a_dpclr: assert property (p_dpclr) else $error("datapath reset pulse");
   property p_pd; o_dp_hold[0] |-> !o_clk_en[0] && !o_link_en[0]; endproperty
   a_pd: assert property (p_pd) else $error("power-down");
   property p_cls; i_rd && i_addr == 16'h0003 |=> o_rdata_ff == CLASS_CODE; endproperty
   a_cls: assert property (p_cls) else $error("class code");
   property p_pri; i_rd && i_addr == 16'h0000 |=> (o_rdata_ff & 8'h99) == 8'h00; endproperty
   a_pri: assert property (p_pri) else $error("primary bits");
   property p_pwr; i_wr && i_addr == 16'h0002 && i_chan_sel[0]
      |=> o_dp_hold[0] == ($past(i_wdata[1:0]) == 2'h3); endproperty
   a_pwr: assert property (p_pwr) else $error("power write");
endmodule // scrb_assertions
bind scrb_top scrb_assertions #(.NUM_CHAN(NUM_CHAN), .CLASS_CODE(CLASS_CODE)) u_scrb_assertions (.i_clk, .i_rst_b,
   .i_wr, .i_rd, .o_port_rst_ff, .o_dp_rst_ff, .o_lsb_first_ff, .o_addr_incr_ff, .i_addr, .i_wdata, .o_rdata_ff,
   .i_chan_sel,
   .o_dp_hold, .o_clk_en, .o_link_en);
`default_nettype wire

// ### testbench/scrb_host.sv
`timescale 1ns/1ps
`default_nettype none
module scrb_host #(parameter SRST_WAIT = 100000) (
   // Bus to the register bank
   input wire logic i_clk,
   input wire logic [7:0] i_rdata,
   output logic o_wr = 1'b0, o_rd = 1'b0,
   output logic [15:0] o_addr = 16'h0000,
   output logic [7:0] o_wdata = 8'h00,
   output logic [1:0] o_sel = 2'h3
);
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_wr <= 1'b1;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_wdata <= ~d;
      if (a == 16'h0000 && (d[0] || d[7])) repeat (SRST_WAIT) @(posedge i_clk);
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] q);
      @(posedge i_clk);
      o_rd <= 1'b1;
      o_addr <= a;
      @(posedge i_clk);
      o_rd <= 1'b0;
      #1 q = i_rdata;
   endtask
endmodule // scrb_host
`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "scrb_defines.vh"
module testbench;
   logic i_clk = 1'b0;
   logic i_rst_b, i_wr, i_rd;
   logic [15:0] i_addr;
   logic [7:0] i_wdata, rdata, q;
   logic [1:0] sel, clk_en, hold, link;
   int fails = 0;
   int checks_done = 0;
   // Address, write data, read-back, then clock enable, link enable and hold of channel A.
   logic [20:0] rows [8] = '{{2'h0, 8'h02, 8'h42, 3'h6}, {2'h0, 8'h20, 8'h24, 3'h6}, {2'h0, 8'h18, 8'h00, 3'h6},
      {2'h1, 8'hFF, 8'h00, 3'h6}, {2'h2, 8'hFE, 8'h02, 3'h2}, {2'h2, 8'h03, 8'h03, 3'h1},
      {2'h3, 8'hFF, `SCRB_CLASS_DEFAULT, 3'h1}, {2'h2, 8'h01, 8'h01, 3'h6}};
   always #25 i_clk = ~i_clk;
   scrb_top u_scrb_top (.i_clk, .i_rst_b, .i_wr, .i_rd, .i_addr, .i_wdata, .i_chan_sel(sel), .o_rdata_ff(rdata),
      .o_lsb_first_ff(), .o_addr_incr_ff(), .o_port_rst_ff(), .o_dp_rst_ff(), .o_clk_en(clk_en),
      .o_dp_hold(hold), .o_link_en(link));
   scrb_host #(.SRST_WAIT(20)) u_scrb_host (.i_clk, .i_rdata(rdata), .o_wr(i_wr), .o_rd(i_rd),
      .o_addr(i_addr), .o_wdata(i_wdata), .o_sel(sel));
   task automatic chk(input string n, input logic [7:0] s, e);
      checks_done++;
      if (s !== e) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", n, e, s);
      end
   endtask
   task automatic wrap_up;
      $display("%0d checks, %0d mismatches", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #100000 fails++;
      wrap_up;
   end
   initial begin
      i_rst_b <= 1'b0;
      repeat (10) @(posedge i_clk);
      i_rst_b <= 1'b1;
      #1 chk("power at reset", {2'h0, clk_en, link, hold}, 8'h3C);
      foreach (rows[i]) begin
         u_scrb_host.wr({14'h0, rows[i][20:19]}, rows[i][18:11]);
         u_scrb_host.rd({14'h0, rows[i][20:19]}, q);
         chk("read-back", q, rows[i][10:3]);
         chk("channel A", {5'h0, clk_en[0], link[0], hold[0]}, {5'h0, rows[i][2:0]});
      end
      @(posedge i_clk) u_scrb_host.o_sel <= 2'h2;
      u_scrb_host.wr(16'h0002, 8'h03);
      @(posedge i_clk) u_scrb_host.o_sel <= 2'h3;
      u_scrb_host.rd(16'h0002, q);
      chk("both selected", {q[5:0], hold}, 8'h06);
      u_scrb_host.wr(16'h0000, 8'h46);
      u_scrb_host.wr(16'h0000, 8'h80);
      u_scrb_host.rd(16'h0000, q);
      chk("after soft reset", {q[5:0], hold}, 8'h00);
      u_scrb_host.rd(16'h0010, q);
      chk("unmapped", q, 8'h00);
      wrap_up;
   end
endmodule // testbench
`default_nettype wire
